// File: logic/dsc_pkg.sv
/*
 * dsc_pkg: constants and carrier types for the host-side controller of a
 * 64K x 16 multiplexed-address asynchronous dynamic memory.
 * assumes a single 100 MHz system clock; all cycle counts below are derived from it.
 */
`default_nettype none
package dsc_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_MHZ          = 100;
   localparam int T_RP_NS          = 45;    // row precharge
   localparam int T_RAS_NS         = 80;    // row strobe low, least
   localparam int T_RAS_MAX_NS     = 10000; // row strobe low, longest
   localparam int T_RAH_NS         = 10;    // row address hold
   localparam int T_CAC_NS         = 30;    // column strobe access
   localparam int T_CSR_NS         = 5;     // column before row setup
   localparam int T_CHR_NS         = 10;    // column hold in refresh
   localparam int T_CPT_NS         = 40;    // counter test column precharge
   localparam int T_CP_NS          = 10;    // column precharge
   localparam int T_WP_NS          = 15;    // write pulse width
   localparam int T_PWR_US         = 200;   // power-up pause
   localparam int T_REF_MS         = 4;     // refresh period
   localparam int REF_ROWS         = 256;
   localparam int INIT_REFRESHES   = 8;
   // least times round up
   localparam int T_RP_CY          = (T_RP_NS * CLK_MHZ + 999) / 1000;
   localparam int T_RAS_CY         = (T_RAS_NS * CLK_MHZ + 999) / 1000;
   localparam int T_RAH_CY         = (T_RAH_NS * CLK_MHZ + 999) / 1000;
   localparam int T_CAC_CY         = (T_CAC_NS * CLK_MHZ + 999) / 1000 + 1;
   localparam int T_CSR_CY         = (T_CSR_NS * CLK_MHZ + 999) / 1000;
   localparam int T_CHR_CY         = (T_CHR_NS * CLK_MHZ + 999) / 1000;
   localparam int T_CPT_CY         = (T_CPT_NS * CLK_MHZ + 999) / 1000;
   localparam int T_CP_CY          = (T_CP_NS * CLK_MHZ + 999) / 1000;
   localparam int T_WP_CY          = (T_WP_NS * CLK_MHZ + 999) / 1000;
   localparam int T_PWR_CY         = T_PWR_US * CLK_MHZ;
   // longest times round down
   localparam int T_RAS_MAX_CY     = T_RAS_MAX_NS * CLK_MHZ / 1000;
   localparam int REF_INTERVAL_CY  = T_REF_MS * 1000 * CLK_MHZ / REF_ROWS;
   // margin so a page closes before the longest row strobe time
   localparam int PAGE_LIMIT_CY    = T_RAS_MAX_CY - 16;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0]
   {
      CMD_READ         = 3'h0,
      CMD_WRITE        = 3'h1,
      CMD_MASKED_WRITE = 3'h2,
      CMD_RMW          = 3'h3,
      CMD_ROW_REFRESH  = 3'h4,
      CMD_COUNTER_TEST = 3'h5
   } dsc_cmd_t;

   typedef struct packed
   {
      dsc_cmd_t    cmd;
      logic [15:0] addr;   // row in upper byte, column in lower byte
      logic [15:0] wdata;
      logic [15:0] mask;   // 1 = bit is written, masked write only
   } dsc_req_t;

   typedef struct packed
   {
      logic        valid;
      logic        err;
      logic [15:0] rdata;
   } dsc_rsp_t;

   typedef struct packed
   {
      logic        row_strobe_n;
      logic        column_strobe_n;
      logic        write_mask_write_enable_n;
      logic        output_enable_n;
      logic [7:0]  shared_address_inputs;
      logic [15:0] data_out;
      logic        data_oe;
   } dsc_pins_t;

endpackage
`default_nettype wire

// File: logic/dsc_divider.sv
/*
 * dsc_divider: reloading cycle counter giving a one-cycle tick every PERIOD
 * enabled cycles. assumes en is synchronous to clk; counting restarts when en drops.
 */
`timescale 1ns/1ps
`default_nettype none
module dsc_divider
#(
   parameter int PERIOD = 1562,
   parameter int W      = 16
)
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic en,
   output var  logic tick
);
   typedef struct packed
   {
      logic [W-1:0] cnt;
      logic         tick;
   } dsc_div_state_t;

   dsc_div_state_t s;
   dsc_div_state_t next_s;

   always_comb
   begin
      next_s      = s;
      next_s.tick = 1'b0;
      if (!en)
      begin
         next_s.cnt = '0;
      end
      else if (s.cnt == W'(PERIOD - 1))
      begin
         next_s.cnt  = '0;
         next_s.tick = 1'b1;
      end
      else
      begin
         next_s.cnt = s.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         s <= '0;
      else
         s <= next_s;
   end

   assign tick = s.tick;
endmodule // dsc_divider
`default_nettype wire

// File: logic/dsc_ctrl.sv
/*
 * dsc_ctrl: host controller driving the strobes, shared address and data pins
 * of a 64K x 16 asynchronous dynamic memory; refresh, page mode, hidden refresh.
 * assumes the memory pins are sampled and driven on clk; data pin input synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module dsc_ctrl
   import dsc_pkg::*;
#(
   parameter int POWER_UP_CYCLES = T_PWR_CY,
   parameter int REF_INTERVAL    = REF_INTERVAL_CY,
   parameter int PAGE_LIMIT      = PAGE_LIMIT_CY
)
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        req_valid,
   input  wire dsc_req_t    req,
   output var  logic        req_ready,
   output var  dsc_rsp_t    rsp,
   output var  logic        init_done,
   output var  dsc_pins_t   pins,
   input  wire logic [15:0] data_in
);
   import dsc_pkg::*;

   typedef enum logic [3:0]
   {
      ST_PWR     = 4'h0,
      ST_IDLE    = 4'h1,
      ST_RAS     = 4'h2,
      ST_RAH     = 4'h3,
      ST_COL     = 4'h4,
      ST_CAS     = 4'h5,
      ST_RMW_OE  = 4'h6,
      ST_RMW_WE  = 4'h7,
      ST_DONE    = 4'h8,
      ST_OPEN    = 4'h9,
      ST_CLOSE   = 4'ha,
      ST_PRE     = 4'hb,
      ST_CBR_CAS = 4'hc,
      ST_CBR_RAS = 4'hd,
      ST_HID     = 4'he,
      ST_CT_CHR  = 4'hf
   } dsc_st_t;

   typedef struct packed
   {
      dsc_st_t    st;
      logic [7:0] wait_cnt;
      logic [9:0] age;       // cycles since row strobe fell
      dsc_req_t   cur;
      logic       pend;      // request taken but not yet started
      logic       ref_pend;
      logic [3:0] cbr_cnt;   // saturates at INIT_REFRESHES
      logic       ct;        // the coming column-first cycle is a counter test
      logic       init;      // initialising refreshes done
      logic       rdy;
      dsc_rsp_t   rsp;
      dsc_pins_t  pins;
   } dsc_state_t;

   dsc_state_t s;
   dsc_state_t next_s;
   logic       pwr_tick;
   logic       ref_tick;
   logic       take;
   logic       is_read;
   logic       is_wr;

   // ************************************************************
   // timers
   // ************************************************************
   // power-up pause
   dsc_divider #(.PERIOD(POWER_UP_CYCLES), .W(16)) u_pwr
   (
      .clk   (clk),
      .rst_b (rst_b),
      .en    (s.st == ST_PWR),
      .tick  (pwr_tick)
   );

   dsc_divider #(.PERIOD(REF_INTERVAL), .W(16)) u_ref
   (
      .clk   (clk),
      .rst_b (rst_b),
      .en    (s.st != ST_PWR),
      .tick  (ref_tick)
   );

   // ************************************************************
   // sequencer
   // ************************************************************
   assign take    = req_valid && s.rdy;
   assign is_read = (s.cur.cmd == CMD_READ) || (s.cur.cmd == CMD_RMW)
                    || (s.cur.cmd == CMD_COUNTER_TEST);
   assign is_wr   = (s.cur.cmd == CMD_WRITE) || (s.cur.cmd == CMD_MASKED_WRITE);

   always_comb
   begin
      next_s           = s;
      next_s.rsp.valid = 1'b0;
      next_s.rsp.err   = 1'b0;
      if (s.wait_cnt != 8'h00)
         next_s.wait_cnt = s.wait_cnt - 8'h01;
      if (s.age != 10'h3ff)
         next_s.age = s.age + 10'h001;
      unique case (s.st)
         ST_PWR:
            if (pwr_tick)
               next_s.st = ST_IDLE;
         ST_IDLE:
            // initial and periodic refreshes take priority
            if (s.cbr_cnt < 4'(INIT_REFRESHES) || s.ref_pend)
            begin
               next_s.pins.column_strobe_n = 1'b0;
               next_s.ref_pend             = 1'b0;
               next_s.ct                   = 1'b0;
               next_s.wait_cnt             = 8'(T_CSR_CY - 1);
               next_s.st                   = ST_CBR_CAS;
            end
            else if (take || s.pend)
            begin
               if (take)
                  next_s.cur = req;
               next_s.pend = 1'b0;
               if ((take ? req.cmd : s.cur.cmd) == CMD_COUNTER_TEST)
               begin
                  next_s.pins.column_strobe_n = 1'b0;
                  next_s.ct                   = 1'b1;
                  next_s.wait_cnt             = 8'(T_CSR_CY - 1);
                  next_s.st                   = ST_CBR_CAS;
               end
               else
               begin
                  // row half first; mask on data pins at row fall
                  next_s.pins.shared_address_inputs =
                     take ? req.addr[15:8] : s.cur.addr[15:8];
                  next_s.pins.write_mask_write_enable_n =
                     ((take ? req.cmd : s.cur.cmd) != CMD_MASKED_WRITE);
                  next_s.pins.data_out = take ? req.mask : s.cur.mask;
                  next_s.pins.data_oe  =
                     ((take ? req.cmd : s.cur.cmd) == CMD_MASKED_WRITE);
                  next_s.st            = ST_RAS;
               end
            end
         ST_RAS:
         begin
            // row strobe falls on a settled row address
            next_s.pins.row_strobe_n = 1'b0;
            next_s.age               = '0;
            next_s.wait_cnt          = 8'(T_RAH_CY - 1);
            next_s.st                = ST_RAH;
         end
         ST_RAH:
            if (s.wait_cnt == 8'h00)
            begin
               // switch to column only after row hold
               next_s.pins.shared_address_inputs     = s.cur.addr[7:0];
               next_s.pins.write_mask_write_enable_n = 1'b1;
               next_s.pins.data_oe                   = 1'b0;
               if (s.cur.cmd == CMD_ROW_REFRESH)
               begin
                  // row-only refresh, column strobe stays high
                  next_s.rsp.valid = 1'b1;
                  next_s.st        = ST_CLOSE;
               end
               else
               begin
                  if (is_wr)
                  begin
                     // early write: enable low before column fall
                     next_s.pins.write_mask_write_enable_n = 1'b0;
                     next_s.pins.data_out                  = s.cur.wdata;
                     next_s.pins.data_oe                   = 1'b1;
                  end
                  next_s.st = ST_COL;
               end
            end
         ST_COL:
            if (s.wait_cnt == 8'h00)
            begin
               // strobe falls with write enable already low for writes
               next_s.pins.column_strobe_n = 1'b0;
               next_s.pins.output_enable_n = !is_read;
               next_s.wait_cnt             = 8'(T_CAC_CY - 1);
               next_s.st                   = ST_CAS;
            end
         ST_CAS:
            if (s.wait_cnt == 8'h00)
            begin
               if (is_read)
                  next_s.rsp.rdata = data_in;
               if (s.cur.cmd == CMD_RMW || s.cur.cmd == CMD_COUNTER_TEST)
               begin
                  // release outputs before driving write data
                  next_s.pins.output_enable_n = 1'b1;
                  next_s.st                   = ST_RMW_OE;
               end
               else
                  next_s.st = ST_DONE;
            end
         ST_RMW_OE:
         begin
            next_s.pins.data_out = s.cur.wdata;
            next_s.pins.data_oe  = 1'b1;
            next_s.st            = ST_RMW_WE;
         end
         ST_RMW_WE:
         begin
            // write enable fall strobes the data in
            next_s.pins.write_mask_write_enable_n = 1'b0;
            next_s.wait_cnt                       = 8'(T_WP_CY - 1);
            next_s.st                             = ST_DONE;
         end
         ST_DONE:
            if (s.wait_cnt == 8'h00)
            begin
               next_s.rsp.valid                      = 1'b1;
               next_s.pins.write_mask_write_enable_n = 1'b1;
               next_s.pins.data_oe                   = 1'b0;
               if (s.cur.cmd == CMD_READ && s.ref_pend && s.age >= 10'(T_RAS_CY))
               begin
                  // hidden refresh, read data stays on the pins
                  next_s.pins.row_strobe_n = 1'b1;
                  next_s.ref_pend          = 1'b0;
                  next_s.wait_cnt          = 8'(T_RP_CY - 1);
                  next_s.st                = ST_HID;
               end
               else
               begin
                  next_s.pins.column_strobe_n = 1'b1;
                  next_s.pins.output_enable_n = 1'b1;
                  next_s.wait_cnt             = 8'(T_CP_CY - 1);
                  next_s.st = (s.cur.cmd == CMD_COUNTER_TEST) ? ST_CLOSE : ST_OPEN;
               end
            end
         ST_OPEN:
            if (s.wait_cnt == 8'h00)
            begin
               if (s.ref_pend || s.age >= 10'(PAGE_LIMIT))
                  next_s.st = ST_CLOSE;
               else if (take)
               begin
                  next_s.cur = req;
                  // a bit mask latched at row fall would still apply to page writes
                  if (req.addr[15:8] == s.cur.addr[15:8]
                      && s.cur.cmd != CMD_MASKED_WRITE
                      && (req.cmd == CMD_READ || req.cmd == CMD_WRITE
                          || req.cmd == CMD_RMW))
                  begin
                     // page access: new column, row strobe kept low
                     next_s.pins.shared_address_inputs = req.addr[7:0];
                     next_s.pins.write_mask_write_enable_n = (req.cmd != CMD_WRITE);
                     next_s.pins.data_out = req.wdata;
                     next_s.pins.data_oe  = (req.cmd == CMD_WRITE);
                     next_s.st            = ST_COL;
                  end
                  else
                  begin
                     next_s.pend = 1'b1;
                     next_s.st   = ST_CLOSE;
                  end
               end
            end
         ST_CLOSE:
            if (s.age >= 10'(T_RAS_CY))
            begin
               next_s.pins.row_strobe_n    = 1'b1;
               next_s.pins.column_strobe_n = 1'b1;
               next_s.pins.output_enable_n = 1'b1;
               next_s.wait_cnt             = 8'(T_RP_CY - 1);
               next_s.st                   = ST_PRE;
            end
         ST_PRE:
            if (s.wait_cnt == 8'h00)
               next_s.st = ST_IDLE;
         ST_CBR_CAS:
            if (s.wait_cnt == 8'h00)
            begin
               // the memory takes its row from its own counter on this edge and steps it when the row strobe rises
               next_s.pins.row_strobe_n = 1'b0;
               next_s.age               = '0;
               if (s.cbr_cnt < 4'(INIT_REFRESHES))
                  next_s.cbr_cnt = s.cbr_cnt + 4'h1;
               // a stale command word must not turn a later refresh into a test
               if (s.ct)
               begin
                  next_s.wait_cnt = 8'(T_CHR_CY - 1);
                  next_s.st       = ST_CT_CHR;
               end
               else
               begin
                  next_s.wait_cnt = 8'(T_RAS_CY - 1);
                  next_s.st       = ST_CBR_RAS;
               end
            end
         ST_CT_CHR:
            if (s.wait_cnt == 8'h00)
            begin
               // column address applied after the counter row
               next_s.pins.column_strobe_n       = 1'b1;
               next_s.pins.shared_address_inputs = s.cur.addr[7:0];
               next_s.wait_cnt                   = 8'(T_CPT_CY - 1);
               next_s.st                         = ST_COL;
            end
         ST_HID:
            if (s.wait_cnt == 8'h00)
            begin
               next_s.pins.row_strobe_n = 1'b0;
               next_s.age               = '0;
               next_s.wait_cnt          = 8'(T_RAS_CY - 1);
               next_s.st                = ST_CBR_RAS;
            end
         ST_CBR_RAS:
            if (s.wait_cnt == 8'h00)
            begin
               next_s.pins.row_strobe_n    = 1'b1;
               next_s.pins.column_strobe_n = 1'b1;
               next_s.pins.output_enable_n = 1'b1;
               next_s.wait_cnt             = 8'(T_RP_CY - 1);
               next_s.st                   = ST_PRE;
            end
      endcase
      // a tick in the clearing cycle is kept
      if (ref_tick)
         next_s.ref_pend = 1'b1;
      next_s.init = (next_s.cbr_cnt >= 4'(INIT_REFRESHES));
      // no page take near the age limit: the open page would close and drop it
      next_s.rdy = (next_s.st == ST_IDLE && !next_s.pend && !next_s.ref_pend && next_s.init)
                   || (next_s.st == ST_OPEN && !next_s.ref_pend
                       && next_s.age < 10'(PAGE_LIMIT));
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s      <= '0;
         s.pins <= '{row_strobe_n: 1'b1, column_strobe_n: 1'b1,
                     write_mask_write_enable_n: 1'b1, output_enable_n: 1'b1,
                     shared_address_inputs: 8'h00, data_out: 16'h0000,
                     data_oe: 1'b0};
      end
      else
         s <= next_s;
   end

   assign req_ready = s.rdy;
   assign rsp       = s.rsp;
   assign pins      = s.pins;
   assign init_done = s.init;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic [15:0] ref_gap;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         ref_gap <= 16'h0000;
      else if (!pins.row_strobe_n && s.pins.column_strobe_n == 1'b0 && s.st == ST_CBR_RAS)
         ref_gap <= 16'h0000;
      else if (s.st != ST_PWR && ref_gap != 16'hffff)
         ref_gap <= ref_gap + 16'h0001;
   end

   sequence s_row_fall;
      $fell(pins.row_strobe_n) && pins.column_strobe_n;
   endsequence
   sequence s_precharge;
      pins.row_strobe_n [*5];
   endsequence

   property p_row_addr;
      s_row_fall |-> pins.shared_address_inputs == s.cur.addr[15:8];
   endproperty
   a_row_addr: assert property (p_row_addr) else $error("row address wrong");

   property p_col_after_hold;
      $fell(pins.column_strobe_n) && !pins.row_strobe_n && $past(!pins.row_strobe_n, 2)
         |-> pins.shared_address_inputs == s.cur.addr[7:0];
   endproperty
   a_col_after_hold: assert property (p_col_after_hold) else $error("column early");

   property p_mask_pins;
      (s_row_fall and !pins.write_mask_write_enable_n) |-> pins.data_oe;
   endproperty
   a_mask_pins: assert property (p_mask_pins) else $error("mask not driven");

   property p_precharge;
      $rose(pins.row_strobe_n) |-> s_precharge;
   endproperty
   a_precharge: assert property (p_precharge) else $error("precharge short");

   property p_cbr_setup;
      $fell(pins.row_strobe_n) && !pins.column_strobe_n |-> $past(!pins.column_strobe_n);
   endproperty
   a_cbr_setup: assert property (p_cbr_setup) else $error("cbr setup short");

   property p_no_clash;
      !pins.output_enable_n |-> !pins.data_oe;
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("data pin clash");

   property p_refresh_gap;
      ref_gap < 16'(2 * REF_INTERVAL + 64);
   endproperty
   a_refresh_gap: assert property (p_refresh_gap) else $error("refresh late");

   property p_early_write;
      $fell(pins.column_strobe_n) && s.pins.data_oe |-> !pins.write_mask_write_enable_n
         && pins.output_enable_n;
   endproperty
   a_early_write: assert property (p_early_write) else $error("not early write");

   property p_init_first;
      req_ready |-> init_done;
   endproperty
   a_init_first: assert property (p_init_first) else $error("ready before init");
endmodule // dsc_ctrl
`default_nettype wire

// File: sim/dsc_mem_model.sv
/* dsc_mem_model: behavioural 64K x 16 memory answering the controller pins.
   assumes pins come from dsc_ctrl; the memory has no clock of its own. */
`timescale 1ns/1ps
`default_nettype none
module dsc_mem_model
   import dsc_pkg::*;
(
   input  wire dsc_pins_t   pins,
   output wire logic [15:0] data_in,
   output var  int          cbr_count
);
   logic [15:0] mem [0:65535];
   logic [15:0] mask;
   logic [15:0] rd;
   logic [7:0]  row;
   logic [7:0]  col;
   logic [7:0]  ctr;
   logic        cbr;
   logic        ew;
   initial
   begin
      cbr_count = 0;
      ctr = 8'h00;
      ew = 1'b1;
      rd = 16'h0000;
      for (int i = 0; i < 65536; i++) mem[i] = 16'h0000;
   end
   always @(negedge pins.row_strobe_n)
   begin
      cbr = !pins.column_strobe_n;
      row = cbr ? ctr : pins.shared_address_inputs;
      mask = pins.write_mask_write_enable_n ? 16'hffff : pins.data_out;
      if (cbr) cbr_count++;
   end
   always @(posedge pins.row_strobe_n) if (cbr) ctr++;
   always @(negedge pins.column_strobe_n)
   begin
      col = pins.shared_address_inputs;
      ew = !pins.write_mask_write_enable_n;
      // the column access waits for the row chain
      #1 if (!pins.row_strobe_n) rd = mem[{row, col}];
   end
   always @(negedge pins.column_strobe_n or negedge pins.write_mask_write_enable_n)
      if (!pins.row_strobe_n && !pins.column_strobe_n && !pins.write_mask_write_enable_n)
         #2 mem[{row, col}] = (mem[{row, col}] & ~mask) | (pins.data_out & mask);
   assign data_in = (!pins.column_strobe_n && !pins.output_enable_n && !ew) ? rd : ~rd;
endmodule // dsc_mem_model
`default_nettype wire

// File: sim/tb_async_dram_strobe_interface.sv
/* tb_async_dram_strobe_interface: directed tests of dsc_ctrl on a memory model.
   assumes shortened power-up and refresh counts. */
`timescale 1ns/1ps
`default_nettype none
module tb_async_dram_strobe_interface;
   import dsc_pkg::*;
   logic        clk = 0, rst_b = 0, req_valid = 0, req_ready, init_done;
   dsc_req_t    req = '0;
   dsc_rsp_t    rsp;
   dsc_pins_t   pins;
   logic [15:0] data_in, got;
   int          cbr_count, c0, err_total = 0, num_checks = 0, cyc = 0;
   always #5 clk = ~clk;
   dsc_ctrl #(.POWER_UP_CYCLES(50), .REF_INTERVAL(200)) i_dut (.clk(clk), .rst_b(rst_b),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp),
      .init_done(init_done), .pins(pins), .data_in(data_in));
   dsc_mem_model i_mem (.pins(pins), .data_in(data_in), .cbr_count(cbr_count));
   // *****
   // tasks
   // *****
   task chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task run(input dsc_cmd_t c, input logic [15:0] a, input logic [15:0] w,
            input logic [15:0] m);
      int n;
      n = 0;
      @(negedge clk);
      req = '{c, a, w, m};
      req_valid = 1'b1;
      while (req_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      while (rsp.valid !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      chk(16'(n < 300), 16'h0001);
      chk(16'(rsp.err), 16'h0000);
      got = rsp.rdata;
   endtask
   task t_write_read;
      run(CMD_WRITE, 16'h1234, 16'ha5c3, 16'h0000);
      run(CMD_READ, 16'h1234, 16'h0000, 16'h0000);
      chk(got, 16'ha5c3);
      $display("test write_read done");
   endtask
   task t_masked_write;
      run(CMD_WRITE, 16'h3456, 16'hffff, 16'h0000);
      run(CMD_MASKED_WRITE, 16'h3456, 16'h0000, 16'h00ff);
      run(CMD_READ, 16'h3456, 16'h0000, 16'h0000);
      chk(got, 16'hff00);
      $display("test masked_write done");
   endtask
   task t_rmw_page;
      run(CMD_RMW, 16'h1234, 16'h0f0f, 16'h0000);
      chk(got, 16'ha5c3);
      run(CMD_WRITE, 16'h1235, 16'h1111, 16'h0000);
      run(CMD_READ, 16'h1234, 16'h0000, 16'h0000);
      chk(got, 16'h0f0f);
      run(CMD_READ, 16'h1235, 16'h0000, 16'h0000);
      chk(got, 16'h1111);
      $display("test rmw_page done");
   endtask
   task t_refresh;
      c0 = cbr_count;
      run(CMD_ROW_REFRESH, 16'h4400, 16'h0000, 16'h0000);
      repeat (450) @(negedge clk);
      chk(16'(cbr_count > c0), 16'h0001);
      // every row of the test column holds its own row number
      for (int r = 0; r < 256; r++)
         run(CMD_WRITE, {8'(r), 8'h77}, {8'(r), 8'h77}, 16'h0000);
      run(CMD_COUNTER_TEST, 16'h0077, 16'hbeef, 16'h0000);
      chk({8'h00, got[7:0]}, 16'h0077);
      run(CMD_READ, {got[15:8], 8'h77}, 16'h0000, 16'h0000);
      chk(got, 16'hbeef);
      $display("test refresh done");
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_total++;
         end_of_test();
      end
   end
   // *****
   // sequence
   // *****
   initial
   begin
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      while (init_done !== 1'b1) @(negedge clk);
      chk(16'(cbr_count >= 8), 16'h0001);
      t_write_read();
      t_masked_write();
      t_rmw_page();
      t_refresh();
      end_of_test();
   end
endmodule // tb_async_dram_strobe_interface
`default_nettype wire
